// File: rtl/plt_logic_tile.sv
// Logic tile: eight slices with shared clock, enable and set/reset.
// Assumes all inputs synchronous to mclk; tile clock sources are
// sampled and their rising edges act as update events.
//
// Notes on behaviour
// - Tile holds eight slices, each one table and one flip-flop.
// - Table takes four inputs, any function, sixteen by one read-only.
// - Flip-flop has optional clock enable and optional set/reset.
// - Device-wide reset clears every flip-flop after configuration completes.
// - Each slice has carry logic for arithmetic and wide functions.
// - One clock enable shared by all eight slices.
// - One shared set/reset, configurable asynchronous or synchronous.
// - Tile clock from one of eight global nets or general routing.
// - Slice output is table result or flip-flop value, per configuration.
// - Without set/reset in use, flip-flops are only cleared while unconfigured and after configuration.
// - Each slice takes carry from previous stage, drives next stage.
// - Flip-flop wake-up state during configuration is always reset.
`timescale 1ns/10ps
`default_nettype none
`include "plt_params.svh"
module plt_logic_tile
  import plt_pkg::*;
(
  input  wire logic                      mclk,            // Clock, 50 MHz
  input  wire logic                      arst_n,          // Async reset
  input  wire logic [`PLT_ADDR_W-1:0]    regAddr,         // Register address
  input  wire logic [`PLT_DATA_W-1:0]    regWdata,        // Write data
  input  wire logic                      regWr,           // Write strobe
  input  wire logic                      regRd,           // Read strobe
  output logic      [`PLT_DATA_W-1:0]    regRdata,        // Read data
  input  wire plt_lut_bus_t              cellIn,          // Table inputs
  input  wire logic [`PLT_NUM_GLOBAL-1:0] globalNetDriver, // Global nets
  input  wire logic                      routeClk,        // Routed clock
  input  wire logic                      tileCe,          // Clock enable
  input  wire logic                      tileSr,          // Set/reset
  input  wire logic                      chainCarryIn,    // Carry in
  output logic      [`PLT_CELLS-1:0]     cellOut,         // Slice outputs
  output logic                           chainCarryOut    // Carry out
);
  plt_tile_state_t tile_reg;
  plt_tile_state_t tile_next;
  plt_cfg_arr_t    cfgArr;
  logic [`PLT_CELLS-1:0] lutRes;
  logic [`PLT_CELLS:0]   chain;
  logic [`PLT_CELLS-1:0] regOutMask;
  logic [`PLT_CELLS-1:0] propMask;
  logic                  tickNow;
  logic                  tickRise;
  logic                  ceOk;
  logic                  srAct;
  logic                  runNow;
  logic                  cellWr;
  logic                  cmdWr;

  function automatic logic isCellAddr(input logic [`PLT_ADDR_W-1:0] a);
    return (a >= `PLT_CELL_BASE) && (a < `PLT_CTRL_ADDR)
        && (a[`PLT_CELL_SHIFT-1:0] == '0);
  endfunction

  function automatic logic [`PLT_CELL_IDX_W-1:0] cellIdx(
    input logic [`PLT_ADDR_W-1:0] a);
    logic [`PLT_ADDR_W-1:0] off;
    off = (a - `PLT_CELL_BASE) >> `PLT_CELL_SHIFT;
    return off[`PLT_CELL_IDX_W-1:0];
  endfunction

  // Top bit of the selector picks routing, else the numbered global net
  function automatic logic selectTick(input plt_ctrl_t c,
                                      input logic [`PLT_NUM_GLOBAL-1:0] g,
                                      input logic r);
    return c.clkSel[3] ? r : g[c.clkSel[2:0]];
  endfunction

  // Unmapped or misaligned addresses fall through every decode and are ignored
  assign cellWr = regWr && isCellAddr(regAddr);
  assign cmdWr  = regWr && (regAddr == `PLT_CMD_ADDR);

  plt_cfg_bank u_cfg (
    .mclk   (mclk),
    .arst_n (arst_n),
    .wrEn   (cellWr),
    .wrIdx  (cellIdx(regAddr)),
    .wrData (plt_cell_cfg_t'(regWdata[`PLT_CELL_CFG_W-1:0])),
    .cfgArr (cfgArr)
  );

  // Carry enters slice zero and leaves slice seven
  assign chain[0]               = chainCarryIn;
  assign chainCarryOut          = tile_reg.carryOut;

  genvar gi;
  generate
    for (gi = 0; gi < `PLT_CELLS; gi++) begin : g_slice
      plt_logic_slice u_slice (
        .lutIn    (cellIn[gi]),
        .cfg      (cfgArr[gi]),
        .carryIn  (chain[gi]),
        .lutOut   (lutRes[gi]),
        .carryOut (chain[gi+1])
      );
      assign regOutMask[gi] = cfgArr[gi].regOut;
      assign propMask[gi]   = cellIn[gi][`PLT_LUT_I1] ^ cellIn[gi][`PLT_LUT_I2];
    end
  endgenerate

  assign runNow   = (tile_reg.phase == PLT_RUN);
  assign tickNow  = selectTick(tile_reg.ctrl, globalNetDriver, routeClk);
  // Tile sources are sampled, so a pulse must stay high for one mclk period
  // at least; a shorter pulse on a global net can be missed entirely.
  assign tickRise = tickNow & ~tile_reg.tickPrev;
  // One enable and one set/reset for the whole tile
  assign ceOk     = ~tile_reg.ctrl.ceUsed | tileCe;
  assign srAct    = tile_reg.ctrl.srUsed & tileSr;

  always_comb begin
    logic [`PLT_CELLS-1:0] ffN;
    ffN                = tile_reg.ff;
    tile_next          = tile_reg;
    tile_next.tickPrev = tickNow;
    unique case (tile_reg.phase)
      PLT_UNCONF: begin
        ffN = '0;
      end
      PLT_GRST: begin
        // Global reset pulse right after configuration completes
        ffN             = '0;
        tile_next.phase = PLT_RUN;
      end
      PLT_RUN: begin
        // Asynchronous mode acts on the next mclk edge, without a tile edge;
        // a true async path is not possible on a single-clock design.
        if (srAct && !tile_reg.ctrl.srSync) begin
          ffN = {`PLT_CELLS{tile_reg.ctrl.srSets}};
        // Sync set/reset outranks the enable, so a held enable cannot block it
        end else if (tickRise && srAct) begin
          ffN = {`PLT_CELLS{tile_reg.ctrl.srSets}};
        end else if (tickRise && ceOk) begin
          ffN = lutRes;
        end
      end
      default: begin
        tile_next.phase = PLT_UNCONF;
        ffN             = '0;
      end
    endcase
    if (cmdWr) begin
      tile_next.phase = regWdata[`PLT_CMD_DONE_BIT] ? PLT_GRST : PLT_UNCONF;
    end
    tile_next.ff = ffN;
    if (runNow) begin
      tile_next.out      = (ffN & regOutMask) | (lutRes & ~regOutMask);
      tile_next.carryOut = chain[`PLT_CELLS];
    end else begin
      tile_next.out      = '0;
      tile_next.carryOut = 1'b0;
    end
    if (regWr && regAddr == `PLT_CTRL_ADDR) begin
      tile_next.ctrl = plt_ctrl_t'(regWdata[`PLT_CTRL_W-1:0]);
    end
    // Read data are zero except in the cycle after a read strobe, so read buses of several
    // tiles can simply be OR-ed together with no extra select.
    tile_next.rdata = '0;
    if (regRd) begin
      if (isCellAddr(regAddr)) begin
        tile_next.rdata = `PLT_DATA_W'(cfgArr[cellIdx(regAddr)]);
      end else if (regAddr == `PLT_CTRL_ADDR) begin
        tile_next.rdata = `PLT_DATA_W'(tile_reg.ctrl);
      end else if (regAddr == `PLT_STAT_ADDR) begin
        tile_next.rdata = `PLT_DATA_W'(tile_reg.phase)
          | (`PLT_DATA_W'(tile_reg.ff) << `PLT_STAT_FF_LSB)
          | (`PLT_DATA_W'(tile_reg.out) << `PLT_STAT_OUT_LSB);
      end
    end
  end

  // The run state lives here and the truth tables in the bank, so withdrawing
  // configuration clears the flip-flops but keeps the tables for a restart.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tile_reg       <= '0;
      tile_reg.phase <= PLT_UNCONF;
      tile_reg.ctrl  <= plt_ctrl_t'(`PLT_CTRL_RESET);
    end else begin
      tile_reg <= tile_next;
    end
  end

  assign regRdata = tile_reg.rdata;
  assign cellOut  = tile_reg.out;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  // Checks on the register path and the slice behaviour
  a_cfg_clears: assert property (
    (!runNow && !cmdWr) |=> (tile_reg.ff == '0) && (cellOut == '0))
    else $error("flip-flops not held clear while unconfigured");

  a_grst_release: assert property (
    (tile_reg.phase == PLT_GRST && !cmdWr) |=> runNow)
    else $error("global reset did not release after one cycle");

  a_done_starts: assert property (
    (cmdWr && regWdata[`PLT_CMD_DONE_BIT]) |=> (tile_reg.phase == PLT_GRST)
      ##1 (tile_reg.ff == '0))
    else $error("configuration done did not clear the tile");

  a_async_sr: assert property (
    (runNow && !cmdWr && tile_reg.ctrl.srUsed && !tile_reg.ctrl.srSync
      && tileSr)
    |=> (tile_reg.ff == {`PLT_CELLS{$past(tile_reg.ctrl.srSets)}}))
    else $error("asynchronous set/reset not applied");

  a_sync_sr_waits: assert property (
    (runNow && !cmdWr && srAct && tile_reg.ctrl.srSync && !tickRise)
    |=> $stable(tile_reg.ff))
    else $error("synchronous set/reset acted without a tile edge");

  a_ce_holds: assert property (
    (runNow && !cmdWr && tile_reg.ctrl.ceUsed && !tileCe && !srAct)
    |=> $stable(tile_reg.ff))
    else $error("flip-flops changed with the shared enable low");

  a_sr_unused: assert property (
    (runNow && !cmdWr && !tile_reg.ctrl.srUsed && !tickRise)
    |=> $stable(tile_reg.ff))
    else $error("flip-flops changed without a tile clock edge");

  a_lut_capture: assert property (
    (runNow && !cmdWr && tickRise && ceOk && !srAct)
    |=> (tile_reg.ff == $past(lutRes)))
    else $error("table result not captured on tile edge");

  a_out_select: assert property (
    (runNow && !cmdWr)
    |=> (((cellOut ^ tile_reg.ff) & $past(regOutMask)) == '0)
     && (((cellOut ^ $past(lutRes)) & ~$past(regOutMask)) == '0))
    else $error("slice output source does not match its mode");

  a_carry_pass: assert property (
    (runNow && !cmdWr && (&propMask))
    |=> (chainCarryOut == $past(chainCarryIn)))
    else $error("carry did not ripple through all slices");

  a_carry_gen: assert property (
    (runNow && !cmdWr && cellIn[`PLT_CELLS-1][`PLT_LUT_I1]
      && cellIn[`PLT_CELLS-1][`PLT_LUT_I2]) |=> chainCarryOut)
    else $error("last slice failed to generate a carry");

  a_read_window: assert property (
    !regRd |=> (regRdata == '0))
    else $error("read data present outside its cycle");

  // Phase sequencing, control and status reads, flip-flop edges and carry end points
  a_cmd_unconf: assert property (
    (cmdWr && !regWdata[`PLT_CMD_DONE_BIT]) |=> (tile_reg.phase == PLT_UNCONF))
    else $error("configuration withdraw did not stop the tile");

  a_unconf_stays: assert property (
    (tile_reg.phase == PLT_UNCONF && !cmdWr) |=> (tile_reg.phase == PLT_UNCONF))
    else $error("tile left the unconfigured state without a command");

  a_run_stays: assert property (
    (runNow && !cmdWr) |=> runNow)
    else $error("tile left the running state without a command");

  a_ctrl_load: assert property (
    (regWr && regAddr == `PLT_CTRL_ADDR) |=> (tile_reg.ctrl == $past(regWdata[`PLT_CTRL_W-1:0])))
    else $error("control write did not take effect");

  a_ctrl_read: assert property (
    (regRd && regAddr == `PLT_CTRL_ADDR) |=> (regRdata == `PLT_DATA_W'($past(tile_reg.ctrl))))
    else $error("control read back does not match the register");

  a_stat_read: assert property (
    (regRd && regAddr == `PLT_STAT_ADDR) |=> (regRdata[1:0] == $past(tile_reg.phase))
      && (regRdata[`PLT_STAT_FF_LSB +: `PLT_CELLS] == $past(tile_reg.ff)))
    else $error("status read back does not match the tile state");

  a_sync_sr_edge: assert property (
    (runNow && !cmdWr && srAct && tile_reg.ctrl.srSync && tickRise)
    |=> (tile_reg.ff == {`PLT_CELLS{$past(tile_reg.ctrl.srSets)}}))
    else $error("synchronous set/reset not applied on tile edge");

  a_edge_only: assert property (
    (runNow && !cmdWr && !tickRise && !(srAct && !tile_reg.ctrl.srSync))
    |=> $stable(tile_reg.ff))
    else $error("flip-flops changed without a selected source edge");

  a_carry_kill: assert property (
    (runNow && !cmdWr && !cellIn[`PLT_CELLS-1][`PLT_LUT_I1]
      && !cellIn[`PLT_CELLS-1][`PLT_LUT_I2]) |=> !chainCarryOut)
    else $error("last slice passed a carry it should have killed");

  a_carry_idle: assert property (
    !runNow |=> !chainCarryOut)
    else $error("carry driven while the tile is not running");

  a_carry_lut: assert property (
    (runNow && !cmdWr && cfgArr[0].carryMode && !cfgArr[0].regOut)
    |=> (cellOut[0] == $past(cfgArr[0].truth[{chainCarryIn, cellIn[0][`PLT_LUT_I2:0]}])))
    else $error("first slice table ignored the incoming carry");
endmodule // plt_logic_tile
`default_nettype wire

// File: rtl/plt_params.svh
// Constants of the logic tile: register map, field positions, sizes.
// Assumes inclusion by bare name from the package and every module.
`ifndef PLT_PARAMS_SVH
`define PLT_PARAMS_SVH
`define PLT_CELLS        8
`define PLT_CELL_IDX_W   3
`define PLT_LUT_ENTRIES  16
`define PLT_LUT_I1       1
`define PLT_LUT_I2       2
`define PLT_LUT_I3       3
`define PLT_NUM_GLOBAL   8
`define PLT_ADDR_W       8
`define PLT_DATA_W       32
`define PLT_CELL_BASE    8'h00
`define PLT_CELL_SHIFT   2
`define PLT_CTRL_ADDR    8'h20
`define PLT_STAT_ADDR    8'h24
`define PLT_CMD_ADDR     8'h28
`define PLT_CELL_CFG_W   18
`define PLT_CTRL_W       8
`define PLT_CTRL_RESET   8'h00
`define PLT_CMD_DONE_BIT 0
`define PLT_STAT_FF_LSB  8
`define PLT_STAT_OUT_LSB 16
`endif

// File: rtl/plt_pkg.sv
// Types shared by the logic tile modules.
// Assumes plt_params.svh sits on the include path.
`include "plt_params.svh"
package plt_pkg;
  typedef logic [`PLT_LUT_I3:0] plt_lut_in_t;
  typedef plt_lut_in_t [`PLT_CELLS-1:0] plt_lut_bus_t;
  typedef struct packed {
    logic                        carryMode;
    logic                        regOut;
    logic [`PLT_LUT_ENTRIES-1:0] truth;
  } plt_cell_cfg_t;
  typedef plt_cell_cfg_t [`PLT_CELLS-1:0] plt_cfg_arr_t;
  typedef struct packed {
    logic       srSets;
    logic       srSync;
    logic       srUsed;
    logic       ceUsed;
    logic [3:0] clkSel;
  } plt_ctrl_t;
  typedef enum logic [1:0] {
    PLT_UNCONF = 2'h0,
    PLT_GRST   = 2'h1,
    PLT_RUN    = 2'h3
  } plt_phase_t;
  typedef struct packed {
    plt_phase_t              phase;
    plt_ctrl_t               ctrl;
    logic                    tickPrev;
    logic [`PLT_CELLS-1:0]   ff;
    logic [`PLT_CELLS-1:0]   out;
    logic                    carryOut;
    logic [`PLT_DATA_W-1:0]  rdata;
  } plt_tile_state_t;
endpackage

// File: rtl/plt_logic_slice.sv
// One logic slice: four-input lookup table and one carry stage.
// Assumes its configuration is held stable by the caller.
`timescale 1ns/10ps
`default_nettype none
`include "plt_params.svh"
module plt_logic_slice
  import plt_pkg::*;
(
  input  wire plt_lut_in_t   lutIn,    // Table address inputs
  input  wire plt_cell_cfg_t cfg,      // Truth table and modes
  input  wire logic          carryIn,  // Carry from previous slice
  output logic               lutOut,   // Table result
  output logic               carryOut  // Carry to next slice
);
  always_comb begin
    logic [`PLT_LUT_I3:0] idx;
    idx = lutIn;
    // In carry mode the top table input follows the carry
    if (cfg.carryMode) begin
      idx[`PLT_LUT_I3] = carryIn;
    end
    lutOut   = cfg.truth[idx];
    carryOut = (lutIn[`PLT_LUT_I1] & lutIn[`PLT_LUT_I2])
             | ((lutIn[`PLT_LUT_I1] | lutIn[`PLT_LUT_I2]) & carryIn);
  end
endmodule // plt_logic_slice
`default_nettype wire

// File: rtl/plt_cfg_bank.sv
// Configuration bank: one truth table and mode pair per slice.
// Assumes one write port; all words are read in parallel.
`timescale 1ns/10ps
`default_nettype none
`include "plt_params.svh"
module plt_cfg_bank
  import plt_pkg::*;
(
  input  wire logic                       mclk,    // Clock
  input  wire logic                       arst_n,  // Async reset
  input  wire logic                       wrEn,    // Write strobe
  input  wire logic [`PLT_CELL_IDX_W-1:0] wrIdx,   // Slice index
  input  wire plt_cell_cfg_t              wrData,  // New word
  output logic                            [`PLT_CELLS*`PLT_CELL_CFG_W-1:0] cfgArr  // All words
);
  plt_cfg_arr_t bank_reg;
  plt_cfg_arr_t bank_next;

  always_comb begin
    bank_next = bank_reg;
    if (wrEn) begin
      bank_next[wrIdx] = wrData;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bank_reg <= '0;
    end else begin
      bank_reg <= bank_next;
    end
  end

  assign cfgArr = bank_reg;
endmodule // plt_cfg_bank
`default_nettype wire

// File: test/plt_fabric_model.sv
// Fabric model: global nets, routed clock source and the neighbour's carry.
// Assumes the bench calls its tasks; clock sources idle low between pulses.
`timescale 1ns/10ps
`default_nettype none
`include "plt_params.svh"
module plt_fabric_model (
  input  wire logic                       mclk,             // Clock
  output var  logic [`PLT_NUM_GLOBAL-1:0] globalNetDriver,  // Global net sources
  output var  logic                       routeClk,         // Routed clock source
  output var  logic                       chainCarryIn      // Carry from previous tile
);
  initial begin
    globalNetDriver = 8'h00;
    routeClk = 1'b0;
    chainCarryIn = 1'b0;
  end

  // One rising edge on the chosen source; 8 picks the routed clock
  task automatic pulse(input int src);
    @(posedge mclk);
    if (src < `PLT_NUM_GLOBAL) begin
      globalNetDriver[src] <= 1'b1;
    end else begin
      routeClk <= 1'b1;
    end
    repeat (2) @(posedge mclk);
    globalNetDriver <= 8'h00;
    routeClk <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  task automatic carry(input logic c);
    @(posedge mclk);
    chainCarryIn <= c;
  endtask
endmodule // plt_fabric_model
`default_nettype wire

// File: test/test_plt_logic_tile.sv
// Bench for the logic tile: register tasks, fabric model and checks.
// Assumes the package, the design and the fabric model are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "plt_params.svh"
module test_plt_logic_tile
  import plt_pkg::*;
;
  logic         mclk = 1'b0;
  logic         arst_n = 1'b0;
  logic [7:0]   regAddr = 8'h00;
  logic [31:0]  regWdata = 32'h0;
  logic         regWr = 1'b0;
  logic         regRd = 1'b0;
  logic         tileCe = 1'b0;
  logic         tileSr = 1'b0;
  plt_lut_bus_t cellIn = '0;
  logic [31:0]  regRdata;
  logic [31:0]  d;
  logic [7:0]   globalNetDriver;
  logic         routeClk;
  logic         chainCarryIn;
  logic [7:0]   cellOut;
  logic         chainCarryOut;
  logic [15:0]  tt [8];
  logic [31:0]  pat [4] = '{32'h22222222, 32'h22226222, 32'h22022222, 32'h66666666};
  int           nFail = 0;
  int           checked = 0;

  always #10 mclk = ~mclk;

  plt_fabric_model fab (.mclk(mclk), .globalNetDriver(globalNetDriver), .routeClk(routeClk),
                        .chainCarryIn(chainCarryIn));

  plt_logic_tile dut (.mclk(mclk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
                      .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cellIn(cellIn),
                      .globalNetDriver(globalNetDriver), .routeClk(routeClk), .tileCe(tileCe),
                      .tileSr(tileSr), .chainCarryIn(chainCarryIn), .cellOut(cellOut),
                      .chainCarryOut(chainCarryOut));

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    d = regRdata;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      nFail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic cfg(input logic regOut, input logic carryMode);
    for (int i = 0; i < 8; i++) wr(8'(4 * i), {14'h0, carryMode, regOut, tt[i]});
  endtask

  task automatic setIdx(input int idx);
    @(posedge mclk);
    cellIn <= {8{4'(idx)}};
  endtask

  task automatic settle;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask

  function automatic logic [31:0] expv(input int idx);
    logic [31:0] e;
    e = 32'h0;
    for (int i = 0; i < 8; i++) e[i] = tt[i][idx];
    return e;
  endfunction

  // Carry is the majority of i1, i2 and the incoming carry, slice 0 first
  function automatic logic [31:0] chain(input plt_lut_bus_t ci, input logic c);
    for (int i = 0; i < 8; i++) c = (ci[i][1] & ci[i][2]) | ((ci[i][1] | ci[i][2]) & c);
    return {31'h0, c};
  endfunction

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    nFail++;
    summarize();
  end

  initial begin
    for (int i = 0; i < 8; i++) tt[i] = 16'(16'h3A5C ^ (16'h1F2B * (i + 1)));
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    rd(`PLT_STAT_ADDR);
    chk(d, 32'h0);
    chk({24'h0, cellOut}, 32'h0);
    rd(`PLT_CTRL_ADDR);
    chk(d, 32'h0);
    wr(`PLT_CTRL_ADDR, 32'hFFFFFFFF);
    wr(8'h21, 32'h0);
    rd(`PLT_CTRL_ADDR);
    chk(d, 32'hFF);
    rd(8'h2C);
    chk(d, 32'h0);
    cfg(1'b0, 1'b0);
    wr(`PLT_CTRL_ADDR, 32'h0);
    wr(`PLT_CMD_ADDR, 32'h1);
    settle();
    rd(`PLT_STAT_ADDR);
    chk(d, 32'h3 | (expv(0) << `PLT_STAT_OUT_LSB));
    rd(8'h1C);
    chk(d, {14'h0, 2'b00, tt[7]});
    for (int idx = 0; idx < 16; idx++) begin
      setIdx(idx);
      settle();
      chk({24'h0, cellOut}, expv(idx));
    end
    cfg(1'b0, 1'b1);
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 2; c++) begin
        fab.carry(1'(c));
        cellIn <= pat[p];
        settle();
        chk({31'h0, chainCarryOut}, chain(pat[p], 1'(c)));
      end
    end
    cfg(1'b1, 1'b0);
    for (int k = 0; k < 9; k++) begin
      wr(`PLT_CTRL_ADDR, 32'(k));
      setIdx(k + 3);
      fab.pulse((k + 1) % 9);
      settle();
      chk({24'h0, cellOut}, (k == 0) ? 32'h0 : expv(k + 2));
      fab.pulse(k);
      settle();
      chk({24'h0, cellOut}, expv(k + 3));
    end
    // Enable gates capture for every slice at once
    wr(`PLT_CTRL_ADDR, 32'h18);
    setIdx(1);
    fab.pulse(8);
    settle();
    chk({24'h0, cellOut}, expv(11));
    @(posedge mclk);
    tileCe <= 1'b1;
    fab.pulse(8);
    settle();
    chk({24'h0, cellOut}, expv(1));
    wr(`PLT_CTRL_ADDR, 32'hA8);
    tileSr <= 1'b1;
    settle();
    chk({24'h0, cellOut}, 32'hFF);
    wr(`PLT_CTRL_ADDR, 32'h68);
    settle();
    chk({24'h0, cellOut}, 32'hFF);
    fab.pulse(8);
    settle();
    chk({24'h0, cellOut}, 32'h0);
    wr(`PLT_CTRL_ADDR, 32'h88);
    fab.pulse(8);
    settle();
    chk({24'h0, cellOut}, expv(1));
    wr(`PLT_CTRL_ADDR, 32'hA8);
    settle();
    @(posedge mclk);
    tileSr <= 1'b0;
    wr(`PLT_CMD_ADDR, 32'h0);
    rd(`PLT_STAT_ADDR);
    chk(d, 32'h0);
    wr(`PLT_CMD_ADDR, 32'h1);
    settle();
    rd(`PLT_STAT_ADDR);
    chk(d, 32'h3);
    summarize();
  end
endmodule // test_plt_logic_tile
`default_nettype wire
